// [include/rc_pkg.sv]
// Shared constants and types of the 16-bit processing core.
// Assumes a 16-bit memory bus answering reads one clock after the request.
package rc_pkg;

	// ----------------------------------------------------------------
	// Widths and reset values
	// ----------------------------------------------------------------
	localparam int unsigned DATA_W = 16;
	localparam int unsigned REG_IDX_W = 4;
	localparam int unsigned NUM_REGS = 16;
	localparam logic [15:0] RESET_VECTOR = 16'hfffe;
	localparam logic [15:0] SR_RESET = 16'h0000;
	localparam logic [15:0] PC_RESET = 16'h0000;
	localparam logic [15:0] REG_RESET = 16'h0000;

	// ----------------------------------------------------------------
	// Dedicated register indices
	// ----------------------------------------------------------------
	localparam logic [3:0] REG_PC = 4'h0;
	localparam logic [3:0] REG_SP = 4'h1;
	localparam logic [3:0] REG_SR = 4'h2;
	localparam logic [3:0] REG_CG = 4'h3;

	// ----------------------------------------------------------------
	// Status flag positions
	// ----------------------------------------------------------------
	localparam int unsigned FLAG_C = 0;
	localparam int unsigned FLAG_Z = 1;
	localparam int unsigned FLAG_N = 2;
	localparam int unsigned FLAG_V = 8;

	// ----------------------------------------------------------------
	// Addressing modes, steps and generated constants
	// ----------------------------------------------------------------
	localparam logic [1:0] AM_REG = 2'h0;
	localparam logic [1:0] AM_INDEX = 2'h1;
	localparam logic [1:0] AM_IND = 2'h2;
	localparam logic [1:0] AM_INC = 2'h3;
	localparam logic [15:0] STEP_WORD = 16'h0002;
	localparam logic [15:0] STEP_BYTE = 16'h0001;
	localparam logic [15:0] CG_ZERO = 16'h0000;
	localparam logic [15:0] CG_ONE = 16'h0001;
	localparam logic [15:0] CG_TWO = 16'h0002;
	localparam logic [15:0] CG_FOUR = 16'h0004;
	localparam logic [15:0] CG_EIGHT = 16'h0008;
	localparam logic [15:0] CG_ALL = 16'hffff;

	// ----------------------------------------------------------------
	// Formats and opcodes
	// ----------------------------------------------------------------
	localparam logic [3:0] FMT_SINGLE = 4'h1;
	localparam logic [2:0] FMT_JUMP = 3'h1;
	localparam logic [3:0] OP_MOV = 4'h4;
	localparam logic [3:0] OP_ADD = 4'h5;
	localparam logic [3:0] OP_ADDC = 4'h6;
	localparam logic [3:0] OP_SUBC = 4'h7;
	localparam logic [3:0] OP_SUB = 4'h8;
	localparam logic [3:0] OP_CMP = 4'h9;
	localparam logic [3:0] OP_DADD = 4'ha;
	localparam logic [3:0] OP_BIT = 4'hb;
	localparam logic [3:0] OP_BIC = 4'hc;
	localparam logic [3:0] OP_BIS = 4'hd;
	localparam logic [3:0] OP_XOR = 4'he;
	localparam logic [3:0] OP_AND = 4'hf;
	localparam logic [2:0] SOP_RRC = 3'h0;
	localparam logic [2:0] SOP_SWPB = 3'h1;
	localparam logic [2:0] SOP_RRA = 3'h2;
	localparam logic [2:0] SOP_SXT = 3'h3;
	localparam logic [2:0] SOP_PUSH = 3'h4;
	localparam logic [2:0] SOP_CALL = 3'h5;
	localparam logic [2:0] SOP_RETI = 3'h6;
	localparam logic [2:0] JC_NE = 3'h0;
	localparam logic [2:0] JC_EQ = 3'h1;
	localparam logic [2:0] JC_NC = 3'h2;
	localparam logic [2:0] JC_C = 3'h3;
	localparam logic [2:0] JC_N = 3'h4;
	localparam logic [2:0] JC_GE = 3'h5;
	localparam logic [2:0] JC_L = 3'h6;
	localparam logic [2:0] JC_ALWAYS = 3'h7;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_RST, ST_RST_LD, ST_DECODE, ST_SRC_EXT, ST_SRC_DATA, ST_DST_EXT,
		ST_DST_DATA, ST_EXEC, ST_WB, ST_POP_SR, ST_POP_PC
	} rc_state_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] wdata;
		logic rd;
		logic wr;
		logic byte_sel;
	} rc_bus_t;

	typedef struct packed {
		logic [15:0] res;
		logic c;
		logic z;
		logic n;
		logic v;
		logic upd;
	} rc_alu_t;

endpackage

// [sim/rc_core_chk.sv]
// Bus-level assertions for the processing core.
// Assumes a bind onto rc_core; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module rc_core_chk import rc_pkg::*; (
	// Clock and reset
	input wire logic clock_i,
	input wire logic reset_i,
	// Memory bus
	input wire logic [15:0] mem_rdata_i,
	input wire rc_bus_t bus_o
);
	// ----------------------------------------------------------------
	// Bus relations
	// ----------------------------------------------------------------
	default clocking @(posedge clock_i); endclocking
	default disable iff (reset_i);

	a_one_request: assert property (!(bus_o.rd && bus_o.wr))
		else $error("read and write in one cycle");
	a_idle_quiet: assert property (!bus_o.rd && !bus_o.wr |-> bus_o == '0)
		else $error("bus not quiet while idle");
	a_write_then_fetch: assert property (bus_o.wr |=> bus_o.rd && !bus_o.byte_sel)
		else $error("write not followed by fetch");
	// One idle cycle is the longest internal step
	a_no_long_idle: assert property (!(bus_o.rd || bus_o.wr) [*2] |=> (bus_o.rd || bus_o.wr))
		else $error("bus idle too long");
	a_byte_dup: assert property (bus_o.wr && bus_o.byte_sel |-> bus_o.wdata[15:8] == bus_o.wdata[7:0])
		else $error("byte write not replicated");
	a_word_even: assert property ((bus_o.rd || bus_o.wr) && !bus_o.byte_sel |-> !bus_o.addr[0])
		else $error("word access at odd address");
	a_reset_vector: assert property ($fell(reset_i) |=> bus_o.rd && bus_o.addr == RESET_VECTOR)
		else $error("no vector read after reset");
	a_first_fetch: assert property ($fell(reset_i) |-> ##2 bus_o.rd && bus_o.addr == $past(mem_rdata_i))
		else $error("first fetch not at vector");
endmodule
bind rc_core rc_core_chk chk (.clock_i(clock_i), .reset_i(reset_i), .mem_rdata_i(mem_rdata_i), .bus_o(bus_o));
`default_nettype wire

// [sim/rc_mem_model.sv]
// Word memory answering the core within the cycle of each read pulse.
// Assumes the bench preloads the array hierarchically.
`timescale 1ns/1ps
`default_nettype none
module rc_mem_model import rc_pkg::*; (
	// Clock
	input wire logic clock_i,
	// Core bus
	input wire rc_bus_t bus_i,
	output logic [15:0] rdata_o
);
	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	logic [15:0] m [0:32767];
	// Core takes the word at the edge ending its registered read pulse
	// Outside a read the data show the inverse, so a stray sample is caught
	assign rdata_o = bus_i.rd ? m[bus_i.addr[15:1]] : ~m[bus_i.addr[15:1]];
	always @(posedge clock_i) begin
		if (bus_i.wr && !bus_i.byte_sel)
			m[bus_i.addr[15:1]] <= bus_i.wdata;
		else if (bus_i.wr && bus_i.addr[0])
			m[bus_i.addr[15:1]][15:8] <= bus_i.wdata[15:8];
		else if (bus_i.wr)
			m[bus_i.addr[15:1]][7:0] <= bus_i.wdata[7:0];
	end
endmodule
`default_nettype wire

// [sim/tb.sv]
// Program-driven bench for the processing core.
// Assumes the memory model and checker beside it.
`timescale 1ns/1ps
`default_nettype none
module tb import rc_pkg::*;;
	// ----------------------------------------------------------------
	// Harness
	// ----------------------------------------------------------------
	logic clock_i = 1'b0;
	logic reset_i = 1'b1;
	logic [15:0] rdata;
	rc_bus_t bus;
	int miscompares = 0;
	int n_checks = 0;
	int cyc = 0;
	int t_rd [int];
	always #20 clock_i = ~clock_i;
	rc_core dut (.clock_i(clock_i), .reset_i(reset_i), .mem_rdata_i(rdata), .bus_o(bus));
	rc_mem_model mem (.clock_i(clock_i), .bus_i(bus), .rdata_o(rdata));
	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		if (bus.rd === 1'b1)
			t_rd[bus.addr] = cyc;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: data %h want %h", $time, got, exp);
		end
	endtask
	task automatic chk_cyc(input int got, input int exp);
		n_checks++;
		if (got != exp) begin
			miscompares++;
			$display("unexpected at %0t: cycles %0d want %0d", $time, got, exp);
		end
	endtask
	function automatic logic [15:0] rdm(input logic [15:0] a);
		return mem.m[a[15:1]];
	endfunction
	task automatic put(input logic [15:0] a, input logic [15:0] w [$]);
		foreach (w[i])
			mem.m[a[15:1] + i] = w[i];
	endtask
	// Fresh memory, start address 0100
	task automatic boot();
		for (int i = 0; i < 32768; i++)
			mem.m[i] = 16'h0000;
		mem.m[16'h7fff] = 16'h0100;
	endtask
	// Reset, then run until the program writes 0200
	task automatic run();
		int n;
		t_rd.delete();
		reset_i = 1'b1;
		repeat (2) @(posedge clock_i);
		#1 reset_i = 1'b0;
		n = 0;
		while (!(bus.wr === 1'b1 && bus.addr === 16'h0200) && n < 400) begin
			@(posedge clock_i);
			#1;
			n++;
		end
		chk_cyc(n < 400, 1);
		@(posedge clock_i);
		#1;
	endtask
	task automatic t_regreg();
		boot();
		put(16'h0100, '{16'h4034, 16'h1234, 16'h4035, 16'h0ff0, 16'h5405, 16'h450f, 16'he40f, 16'h44c2,
			16'h0202, 16'h44c2, 16'h0205, 16'h4239, 16'h4982, 16'h0206, 16'h4f82, 16'h0200});
		put(16'h0202, '{16'hffff, 16'hffff});
		run();
		for (int a = 16'h0108; a < 16'h010e; a += 2)
			chk_cyc(t_rd[a + 2] - t_rd[a], 1);
		chk(rdm(16'h0200), 16'h3010);
		chk(rdm(16'h0202), 16'hff34);
		chk(rdm(16'h0204), 16'h34ff);
		chk(rdm(16'h0206), 16'h0008);
		$display("t_regreg done");
	endtask
	task automatic t_modes();
		boot();
		put(16'h0100, '{16'h4036, 16'h0300, 16'h4637, 16'h5627, 16'h5617, 16'h0002, 16'h4786, 16'h0004,
			16'h4682, 16'h0206, 16'h4018, 16'h01ea, 16'h4882, 16'h0208, 16'h40b2, 16'h0005, 16'h0200});
		put(16'h0300, '{16'h1111, 16'h2222, 16'h0004});
		run();
		chk(rdm(16'h0206), 16'h0302);
		chk(rdm(16'h0306), 16'h3337);
		chk(rdm(16'h0208), 16'h1111);
		chk(rdm(16'h0200), 16'h0005);
		$display("t_modes done");
	endtask
	task automatic t_flow();
		boot();
		put(16'h0100, '{16'h4031, 16'h0400, 16'h4035, 16'h0140, 16'h4520, 16'h40b2, 16'h00cc, 16'h0204,
			16'h4034, 16'h0120, 16'h1284});
		put(16'h0120, '{16'h9404, 16'h2001, 16'h40b2, 16'h00aa, 16'h0202, 16'h9403, 16'h2003,
			16'h40b2, 16'h00bb, 16'h0202, 16'h40b2, 16'h0005, 16'h0200});
		put(16'h0140, '{16'h0110});
		run();
		chk(rdm(16'h03fe), 16'h0116);
		chk(rdm(16'h0204), 16'h0000);
		chk(rdm(16'h0202), 16'h00aa);
		chk(rdm(16'h0200), 16'h0005);
		$display("t_flow done");
	endtask
	task automatic t_ops();
		boot();
		put(16'h0100, '{16'h4031, 16'h0400, 16'h4034, 16'h1280, 16'h1084, 16'h1104, 16'h1204, 16'h4035,
			16'h0301, 16'h4576, 16'h4582, 16'h0202, 16'h4682, 16'h0204, 16'h40b2, 16'h0005, 16'h0200});
		put(16'h0300, '{16'hab12});
		run();
		chk(rdm(16'h03fe), 16'hc009);
		chk(rdm(16'h0202), 16'h0302);
		chk(rdm(16'h0204), 16'h00ab);
		$display("t_ops done");
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		#1;
		t_regreg();
		t_modes();
		t_flow();
		t_ops();
		end_sim();
	end
	// Four short programs need well under this
	initial begin
		repeat (3000) @(posedge clock_i);
		miscompares++;
		$display("unexpected at %0t: watchdog", $time);
		end_sim();
	end
endmodule
`default_nettype wire

// [verilog/rc_core.sv]
// Instruction decode and execution of the 16-bit processing core.
// Assumes memory and peripherals answer a read with data one clock later.
// Overview of operation
// - Register-to-register instructions finish in the cycle their word arrives.
// - Sixteen registers, addressed by instruction fields.
// - Registers 0 to 3 are program counter, stack pointer, status, constant source.
// - All other registers serve any instruction as plain operands.
// - Seven source modes, four destination modes.
// - Dual-operand, single-operand and relative jump formats are decoded.
// - Non-flow instructions run as register operations, memory via addressing modes.
// - Word width by default, byte width when the byte bit is set.
// - Single format has one operand; subroutine call pushes return address, loads target.
// - Conditional and unconditional jumps; not-equal jump taken on clear zero flag.
// - Computed branch and call take any source mode, indirect ones included.
// - Peripherals sit on the address, data and control bus as memory.
`timescale 1ns/1ps
`default_nettype none
module rc_core import rc_pkg::*; (
	// Clock and reset
	input wire logic clock_i,
	input wire logic reset_i,
	// Memory and peripheral bus
	input wire logic [15:0] mem_rdata_i,
	output rc_bus_t bus_o
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	rc_state_t state, next_state;
	logic [15:0] pc, next_pc;
	logic [15:0] sr, next_sr;
	logic [15:0] ir, next_ir;
	logic [15:0] src_q, next_src_q;
	logic [15:0] dst_q, next_dst_q;
	logic [15:0] base_q, next_base_q;
	logic [15:0] op_addr, next_op_addr;
	logic [15:0] dst_addr, next_dst_addr;
	rc_bus_t next_bus;

	logic [15:0] cur_ir, rf_a, rf_b, reg_a, reg_b, cg_val, fast_val, step;
	logic [3:0] f_src, f_dst, op_reg, rf_b_idx;
	logic [1:0] f_as;
	logic f_ad, f_bw, is_jump, is_single, is_dual, cg_hit, fast_src, need_ext, immed, valid_op;
	logic rf_we, wr_en, mr_en, mw_en, do_fetch, do_finish, src_ready, taken;
	logic [3:0] wr_idx;
	logic [15:0] wr_val, mr_addr, mw_addr, mw_data, src_val, fin_src, fin_dst, tmp;
	rc_alu_t alu;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] lane(input logic [15:0] d, input logic odd, input logic bw);
		if (!bw) begin
			return d;
		end
		return odd ? {8'h00, d[15:8]} : {8'h00, d[7:0]};
	endfunction

	function automatic logic msb(input logic [15:0] d, input logic bw);
		return bw ? d[7] : d[15];
	endfunction

	function automatic rc_alu_t alu_dual(input logic [3:0] op, input logic [15:0] s, input logic [15:0] d,
		input logic cin, input logic bw);
		logic [15:0] sv, r, dr;
		logic [16:0] sum17;
		logic [8:0] sum9;
		logic [4:0] t;
		logic ci, carry, dc, dc8;
		rc_alu_t o;
		sv = s;
		ci = 1'b0;
		dc = cin;
		dc8 = 1'b0;
		dr = 16'h0000;
		o = '0;
		case (op)
			OP_ADDC: ci = cin;
			OP_SUB, OP_CMP: begin
				sv = ~s;
				ci = 1'b1;
			end
			OP_SUBC: begin
				sv = ~s;
				ci = cin;
			end
			default: ci = 1'b0;
		endcase
		sum9 = {1'b0, d[7:0]} + {1'b0, sv[7:0]} + {8'h00, ci};
		sum17 = {1'b0, d} + {1'b0, sv} + {16'h0000, ci};
		carry = bw ? sum9[8] : sum17[16];
		// Decimal add, nibble by nibble; byte form takes its carry from nibble one
		for (int i = 0; i < 4; i++) begin
			t = {1'b0, d[4*i +: 4]} + {1'b0, s[4*i +: 4]} + {4'h0, dc};
			if (t > 5'h09) begin
				t = t + 5'h06;
			end
			dc = t[4];
			dr[4*i +: 4] = t[3:0];
			if (i == 1) begin
				dc8 = dc;
			end
		end
		case (op)
			OP_MOV: r = s;
			OP_DADD: r = dr;
			OP_BIT, OP_AND: r = d & s;
			OP_BIC: r = d & ~s;
			OP_BIS: r = d | s;
			OP_XOR: r = d ^ s;
			default: r = sum17[15:0];
		endcase
		if (bw) begin
			r = {8'h00, r[7:0]};
		end
		o.res = r;
		o.n = msb(r, bw);
		o.z = bw ? (r[7:0] == 8'h00) : (r == 16'h0000);
		o.upd = !(op == OP_MOV || op == OP_BIC || op == OP_BIS);
		case (op)
			OP_DADD: o.c = bw ? dc8 : dc;
			OP_BIT, OP_AND, OP_XOR: o.c = !o.z;
			default: o.c = carry;
		endcase
		if (op == OP_XOR) begin
			o.v = msb(s, bw) & msb(d, bw);
		end else if (op == OP_DADD || op == OP_BIT || op == OP_AND) begin
			o.v = 1'b0;
		end else begin
			o.v = (msb(d, bw) == msb(sv, bw)) && (o.n != msb(d, bw));
		end
		return o;
	endfunction

	// ----------------------------------------------------------------
	// Field decode
	// ----------------------------------------------------------------
	always_comb begin
		cur_ir = (state == ST_DECODE) ? mem_rdata_i : ir;
		f_src = cur_ir[11:8];
		f_ad = cur_ir[7];
		f_bw = cur_ir[6];
		f_as = cur_ir[5:4];
		f_dst = cur_ir[3:0];
		is_jump = (cur_ir[15:13] == FMT_JUMP);
		is_single = (cur_ir[15:12] == FMT_SINGLE);
		is_dual = (cur_ir[15:12] >= OP_MOV);
		valid_op = is_dual || (is_single && cur_ir[11:10] == 2'h0 && cur_ir[9:7] <= SOP_CALL);
		op_reg = is_single ? f_dst : f_src;
		rf_b_idx = is_single ? REG_SP : f_dst;
		// Counter, status and constant source live here, the rest, stack pointer included, in the register storage
		reg_a = (op_reg == REG_PC) ? pc : (op_reg == REG_SR) ? sr : (op_reg == REG_CG) ? CG_ZERO : rf_a;
		reg_b = (rf_b_idx == REG_PC) ? pc : (rf_b_idx == REG_SR) ? sr : (rf_b_idx == REG_CG) ? CG_ZERO : rf_b;
		cg_hit = (op_reg == REG_CG) || (op_reg == REG_SR && f_as[1]);
		case (f_as)
			AM_REG: cg_val = CG_ZERO;
			AM_INDEX: cg_val = CG_ONE;
			AM_IND: cg_val = (op_reg == REG_SR) ? CG_FOUR : CG_TWO;
			default: cg_val = (op_reg == REG_SR) ? CG_EIGHT : CG_ALL;
		endcase
		fast_src = (f_as == AM_REG) || cg_hit;
		fast_val = cg_hit ? cg_val : reg_a;
		immed = (op_reg == REG_PC) && (f_as == AM_INC);
		need_ext = !cg_hit && ((f_as == AM_INDEX) || immed);
		step = (f_bw && op_reg != REG_SP) ? STEP_BYTE : STEP_WORD;
		case (cur_ir[12:10])
			JC_NE: taken = !sr[FLAG_Z];
			JC_EQ: taken = sr[FLAG_Z];
			JC_NC: taken = !sr[FLAG_C];
			JC_C: taken = sr[FLAG_C];
			JC_N: taken = sr[FLAG_N];
			JC_GE: taken = !(sr[FLAG_N] ^ sr[FLAG_V]);
			JC_L: taken = sr[FLAG_N] ^ sr[FLAG_V];
			default: taken = 1'b1;
		endcase
		fin_src = (state == ST_DECODE) ? fast_val : src_q;
		fin_dst = f_ad ? dst_q : reg_b;
		alu = alu_dual(cur_ir[15:12], fin_src, fin_dst, sr[FLAG_C], f_bw);
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_pc = pc;
		next_sr = sr;
		next_ir = ir;
		next_src_q = src_q;
		next_dst_q = dst_q;
		next_base_q = base_q;
		next_op_addr = op_addr;
		next_dst_addr = dst_addr;
		next_bus = '0;
		wr_en = 1'b0;
		wr_idx = REG_CG;
		wr_val = 16'h0000;
		mr_en = 1'b0;
		mr_addr = 16'h0000;
		mw_en = 1'b0;
		mw_addr = 16'h0000;
		mw_data = 16'h0000;
		do_fetch = 1'b0;
		do_finish = 1'b0;
		src_ready = 1'b0;
		src_val = 16'h0000;
		tmp = 16'h0000;
		rf_we = 1'b0;
		case (state)
			ST_RST: begin
				mr_en = 1'b1;
				mr_addr = RESET_VECTOR;
				next_state = ST_RST_LD;
			end
			ST_RST_LD: begin
				next_pc = mem_rdata_i;
				do_fetch = 1'b1;
			end
			ST_DECODE: begin
				next_ir = mem_rdata_i;
				if (is_jump) begin
					if (taken) begin
						next_pc = pc + {cur_ir[9], cur_ir[9], cur_ir[9], cur_ir[9], cur_ir[9], cur_ir[9:0], 1'b0};
					end
					do_fetch = 1'b1;
				end else if (is_single && cur_ir[9:7] == SOP_RETI && cur_ir[11:10] == 2'h0) begin
					mr_en = 1'b1;
					mr_addr = reg_b;
					wr_en = 1'b1;
					wr_idx = REG_SP;
					wr_val = reg_b + STEP_WORD;
					next_state = ST_POP_SR;
				end else if (!valid_op) begin
					do_fetch = 1'b1;
				end else if (fast_src) begin
					if (is_dual && f_ad) begin
						src_ready = 1'b1;
						src_val = fast_val;
					end else begin
						do_finish = 1'b1;
					end
				end else if (need_ext) begin
					mr_en = 1'b1;
					mr_addr = pc;
					next_pc = pc + STEP_WORD;
					// Absolute mode reuses the status index with a zero base
					next_base_q = (op_reg == REG_SR) ? CG_ZERO : reg_a;
					next_state = ST_SRC_EXT;
				end else begin
					mr_en = 1'b1;
					mr_addr = reg_a;
					next_op_addr = reg_a;
					if (f_as == AM_INC) begin
						wr_en = 1'b1;
						wr_idx = op_reg;
						wr_val = reg_a + step;
					end
					next_state = ST_SRC_DATA;
				end
			end
			ST_SRC_EXT: begin
				if (immed) begin
					src_ready = 1'b1;
					src_val = mem_rdata_i;
				end else begin
					tmp = mem_rdata_i + base_q;
					mr_en = 1'b1;
					mr_addr = tmp;
					next_op_addr = tmp;
					next_state = ST_SRC_DATA;
				end
			end
			ST_SRC_DATA: begin
				src_ready = 1'b1;
				src_val = lane(mem_rdata_i, op_addr[0], f_bw);
			end
			ST_DST_EXT: begin
				tmp = mem_rdata_i + base_q;
				next_dst_addr = tmp;
				if (cur_ir[15:12] == OP_MOV) begin
					next_state = ST_EXEC;
				end else begin
					mr_en = 1'b1;
					mr_addr = tmp;
					next_state = ST_DST_DATA;
				end
			end
			ST_DST_DATA: begin
				next_dst_q = lane(mem_rdata_i, dst_addr[0], f_bw);
				next_state = ST_EXEC;
			end
			ST_EXEC: do_finish = 1'b1;
			ST_WB: do_fetch = 1'b1;
			ST_POP_SR: begin
				next_sr = mem_rdata_i;
				mr_en = 1'b1;
				mr_addr = reg_b;
				wr_en = 1'b1;
				wr_idx = REG_SP;
				wr_val = reg_b + STEP_WORD;
				next_state = ST_POP_PC;
			end
			ST_POP_PC: begin
				next_pc = mem_rdata_i;
				do_fetch = 1'b1;
			end
			default: next_state = ST_RST;
		endcase

		// Source in hand: destination address from its extension word, else execute
		if (src_ready) begin
			next_src_q = src_val;
			if (is_dual && f_ad) begin
				mr_en = 1'b1;
				mr_addr = pc;
				next_pc = pc + STEP_WORD;
				next_base_q = (f_dst == REG_SR) ? CG_ZERO : reg_b;
				next_state = ST_DST_EXT;
			end else begin
				next_state = ST_EXEC;
			end
		end

		if (do_finish) begin
			if (is_dual) begin
				if (alu.upd) begin
					next_sr[FLAG_C] = alu.c;
					next_sr[FLAG_Z] = alu.z;
					next_sr[FLAG_N] = alu.n;
					next_sr[FLAG_V] = alu.v;
				end
				if (cur_ir[15:12] == OP_CMP || cur_ir[15:12] == OP_BIT) begin
					do_fetch = 1'b1;
				end else if (f_ad) begin
					mw_en = 1'b1;
					mw_addr = dst_addr;
					mw_data = alu.res;
				end else begin
					// Writing the counter is the computed_branch
					wr_en = 1'b1;
					wr_idx = f_dst;
					wr_val = alu.res;
					do_fetch = 1'b1;
				end
			end else begin
				case (cur_ir[9:7])
					SOP_PUSH: begin
						wr_en = 1'b1;
						wr_idx = REG_SP;
						wr_val = reg_b - STEP_WORD;
						mw_en = 1'b1;
						mw_addr = reg_b - STEP_WORD;
						mw_data = fin_src;
					end
					SOP_CALL: begin
						wr_en = 1'b1;
						wr_idx = REG_SP;
						wr_val = reg_b - STEP_WORD;
						mw_en = 1'b1;
						mw_addr = reg_b - STEP_WORD;
						mw_data = pc;
						next_pc = fin_src;
					end
					default: begin
						case (cur_ir[9:7])
							SOP_RRC: tmp = f_bw ? {8'h00, sr[FLAG_C], fin_src[7:1]} : {sr[FLAG_C], fin_src[15:1]};
							SOP_RRA: tmp = f_bw ? {8'h00, fin_src[7], fin_src[7:1]} : {fin_src[15], fin_src[15:1]};
							SOP_SXT: tmp = {{8{fin_src[7]}}, fin_src[7:0]};
							default: tmp = {fin_src[7:0], fin_src[15:8]};
						endcase
						if (cur_ir[9:7] != SOP_SWPB) begin
							next_sr[FLAG_N] = (cur_ir[9:7] == SOP_SXT) ? tmp[15] : msb(tmp, f_bw);
							next_sr[FLAG_Z] = (cur_ir[9:7] == SOP_SXT) ? (tmp == 16'h0000) :
								(f_bw ? (tmp[7:0] == 8'h00) : (tmp == 16'h0000));
							next_sr[FLAG_C] = (cur_ir[9:7] == SOP_SXT) ? (tmp != 16'h0000) : fin_src[0];
							next_sr[FLAG_V] = 1'b0;
						end
						if (f_as == AM_REG) begin
							wr_en = 1'b1;
							wr_idx = op_reg;
							wr_val = tmp;
							do_fetch = 1'b1;
						end else begin
							mw_en = 1'b1;
							mw_addr = op_addr;
							mw_data = tmp;
						end
					end
				endcase
			end
		end

		// A register write to the status register wins over the flag update
		if (wr_en) begin
			if (wr_idx == REG_PC) begin
				next_pc = wr_val;
			end else if (wr_idx == REG_SR) begin
				next_sr = wr_val;
			end else if (wr_idx != REG_CG) begin
				rf_we = 1'b1;
			end
		end
		// Peripherals are reached by the same reads and writes as memory
		if (mr_en) begin
			next_bus.addr = mr_addr;
			next_bus.rd = 1'b1;
			next_bus.byte_sel = f_bw && (state != ST_RST) && (state != ST_POP_SR) && !src_ready && !do_fetch;
		end
		if (mw_en) begin
			next_bus.addr = mw_addr;
			next_bus.wr = 1'b1;
			next_bus.byte_sel = f_bw;
			next_bus.wdata = f_bw ? {mw_data[7:0], mw_data[7:0]} : mw_data;
			next_state = ST_WB;
		end
		if (do_fetch) begin
			next_bus = '0;
			next_bus.addr = next_pc;
			next_bus.rd = 1'b1;
			next_pc = next_pc + STEP_WORD;
			next_state = ST_DECODE;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			state <= ST_RST;
			pc <= PC_RESET;
			sr <= SR_RESET;
			ir <= REG_RESET;
			src_q <= REG_RESET;
			dst_q <= REG_RESET;
			base_q <= REG_RESET;
			op_addr <= REG_RESET;
			dst_addr <= REG_RESET;
			bus_o <= '0;
		end else begin
			state <= next_state;
			pc <= next_pc;
			sr <= next_sr;
			ir <= next_ir;
			src_q <= next_src_q;
			dst_q <= next_dst_q;
			base_q <= next_base_q;
			op_addr <= next_op_addr;
			dst_addr <= next_dst_addr;
			bus_o <= next_bus;
		end
	end

	rc_regfile #(
		.REGS(NUM_REGS),
		.IDX_W(REG_IDX_W)
	) u_regs (
		.clock_i(clock_i),
		.reset_i(reset_i),
		.we_i(rf_we),
		.widx_i(wr_idx),
		.wdata_i(wr_val),
		.a_idx_i(op_reg),
		.a_o(rf_a),
		.b_idx_i(rf_b_idx),
		.b_o(rf_b)
	);
endmodule
`default_nettype wire

// [verilog/rc_regfile.sv]
// Register storage of the processing core, one write and two read ports.
// Assumes the core routes the dedicated registers itself.
`timescale 1ns/1ps
`default_nettype none
module rc_regfile import rc_pkg::*; #(
	parameter int unsigned REGS = NUM_REGS,
	parameter int unsigned IDX_W = REG_IDX_W
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic reset_i,
	// Write port
	input wire logic we_i,
	input wire logic [IDX_W-1:0] widx_i,
	input wire logic [15:0] wdata_i,
	// Read ports
	input wire logic [IDX_W-1:0] a_idx_i,
	output logic [15:0] a_o,
	input wire logic [IDX_W-1:0] b_idx_i,
	output logic [15:0] b_o
);
	logic [15:0] mem [REGS];
	logic [15:0] next_mem [REGS];

	if (REGS != (1 << IDX_W)) begin : g_chk
		$error("rc_regfile: REGS must equal 2**IDX_W");
	end

	// ----------------------------------------------------------------
	// Storage entries
	// ----------------------------------------------------------------
	for (genvar i = 0; i < REGS; i++) begin : g_ent
		always_comb begin
			next_mem[i] = mem[i];
			if (we_i && (widx_i == IDX_W'(i))) begin
				next_mem[i] = wdata_i;
			end
		end
		always_ff @(posedge clock_i or posedge reset_i) begin
			if (reset_i) begin
				mem[i] <= REG_RESET;
			end else begin
				mem[i] <= next_mem[i];
			end
		end
	end

	// Reads bypass nothing: a write lands at the edge, so the core sees it next cycle
	assign a_o = mem[a_idx_i];
	assign b_o = mem[b_idx_i];
endmodule
`default_nettype wire
